// ==== core/sho_core.sv ====
// Subtract and halt execution core with AXI4-Lite register access
// Contract
// - Literal-minus-accumulator: immediate minus W, result written into W.
// - Subtracts update borrow-inverse, half-borrow and result-null flags from the subtractor outputs.
// - Register-minus-accumulator: file minus W, dest 0 to W, 1 to file.
// - Borrow form also subtracts inverted borrow-inverse flag; stores per dest bit.
// - Halt clears power-down flag and sets watchdog-expiry flag.
// - Halt loads watchdog counter with zero and clears its prescaler.
// - After halt the core stops its oscillator and executes nothing more until a write of 1 to bit 0 of the wake register.
// - One instruction cycle equals four oscillator periods.
// - Each subtract and halt operation completes in one instruction cycle.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module sho_core
  import sho_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             halted
);
  import sho_pkg::*;

  sho_state_t s;
  sho_state_t next_s;

  logic [7:0] alu_a;
  logic       alu_cin;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_dc;
  logic       alu_z;
  sho_sel_t   wsel;
  sho_sel_t   rsel;

  function automatic sho_sel_t reg_sel(input logic [11:0] addr);
    sho_sel_t sel;
    sel = SEL_NONE;
    if ((addr & FILE_MASK) == OFF_FILE)
      sel = SEL_FILE;
    else if (addr == OFF_INSTR)
      sel = SEL_INSTR;
    else if (addr == OFF_ACC)
      sel = SEL_ACC;
    else if (addr == OFF_STATUS)
      sel = SEL_STATUS;
    else if (addr == OFF_WDT)
      sel = SEL_WDT;
    else if (addr == OFF_WAKE)
      sel = SEL_WAKE;
    return sel;
  endfunction : reg_sel

  // Byte-lane merge of a write onto the current register contents
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction : wmerge

  always_comb
  begin
    alu_a   = (s.instr.op == OP_LIT) ? s.instr.lit : s.file[s.instr.faddr];
    alu_cin = (s.instr.op == OP_BORROW) ? s.status.borrow_inv_flag : CARRY_NONE;
  end

  sho_sub u_sub (
    .minuend     (alu_a),
    .subtrahend  (s.acc),
    .carry_in    (alu_cin),
    .result      (alu_res),
    .borrow_inv  (alu_c),
    .half_borrow (alu_dc),
    .result_null (alu_z)
  );

  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    next_s = s;
    wsel   = reg_sel(s.awaddr);
    rsel   = reg_sel(araddr);

    // four oscillator periods per instruction cycle
    if (!s.status.halted)
      next_s.q = s.q + 2'h1;

    // Watchdog prescaler ticks once per instruction cycle while running
    if (!s.status.halted && s.q == Q_LAST)
    begin
      next_s.prescaler = s.prescaler + BYTE_ONE;
      if (s.prescaler == 8'hff)
        next_s.watchdog_counter = s.watchdog_counter + BYTE_ONE;
    end

    // Write channel: address and data taken in either order
    if (s.awready && awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
    end
    if (s.wready && wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;

    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (wsel)
        SEL_INSTR:
        begin
          // Refused while an instruction is in flight or the core is halted
          if (s.st == ST_IDLE && !s.status.halted)
          begin
            merged       = wmerge({14'h0000, s.instr}, s.wdata, s.wstrb);
            next_s.instr = sho_instr_t'(merged[17:0]);
            next_s.st    = ST_WAIT;
          end
          else
            next_s.bresp = RESP_SLVERR;
        end
        SEL_ACC:
        begin
          merged     = wmerge({24'h000000, s.acc}, s.wdata, s.wstrb);
          next_s.acc = merged[7:0];
        end
        SEL_STATUS:
        begin
          // Only the arithmetic flags are writable, so chains can be seeded
          if (s.wstrb[0])
          begin
            next_s.status.borrow_inv_flag  = s.wdata[0];
            next_s.status.half_borrow_flag = s.wdata[1];
            next_s.status.result_null_flag = s.wdata[2];
          end
        end
        SEL_WAKE:
        begin
          if (s.wstrb[0] && s.wdata[0])
            next_s.status.halted = 1'b0;
        end
        SEL_FILE:
        begin
          if (s.wstrb[0])
            next_s.file[s.awaddr[8:2]] = s.wdata[7:0];
        end
        SEL_WDT:
          next_s.bresp = RESP_OKAY;
        default:
          next_s.bresp = RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // Read channel: one read in flight, data one cycle after the address
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (s.arready && arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (rsel)
        SEL_INSTR:  next_s.rdata = {14'h0000, s.instr};
        SEL_ACC:    next_s.rdata = {24'h000000, s.acc};
        SEL_STATUS: next_s.rdata = {25'h0000000, s.status};
        SEL_WDT:    next_s.rdata = {16'h0000, s.prescaler, s.watchdog_counter};
        SEL_WAKE:   next_s.rdata = 32'h0000_0000;
        SEL_FILE:   next_s.rdata = {24'h000000, s.file[araddr[8:2]]};
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Execution sequencer; commit overrides a same-cycle software write
    case (s.st)
      // Issue from an instruction write above must survive this branch
      ST_IDLE:
      begin
      end
      ST_WAIT:
      begin
        if (!s.status.halted && s.q == Q_LAST)
          next_s.st = ST_EXEC;
      end
      ST_EXEC:
      begin
        // commit at the end of one instruction cycle
        if (s.q == Q_LAST)
        begin
          next_s.st = ST_IDLE;
          if (s.instr.op == OP_HALT)
          begin
            next_s.status.power_down_flag      = 1'b0;
            next_s.status.watchdog_expiry_flag = 1'b1;
            next_s.watchdog_counter = WDT_CLEAR;
            next_s.prescaler        = WDT_CLEAR;
            next_s.status.halted = 1'b1;
            next_s.q             = 2'h0;
          end
          else
          begin
            next_s.status.borrow_inv_flag  = alu_c;
            next_s.status.half_borrow_flag = alu_dc;
            next_s.status.result_null_flag = alu_z;
            // destination bit picks W or file
            if (s.instr.op != OP_LIT && s.instr.dest)
              next_s.file[s.instr.faddr] = alu_res;
            else
              next_s.acc = alu_res;
          end
        end
      end
      default:
        next_s.st = ST_IDLE;
    endcase
    next_s.status.busy = (next_s.st != ST_IDLE);
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s         <= '0;
      s.st      <= ST_IDLE;
      s.status  <= STATUS_RST;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;
  assign halted  = s.status.halted;

endmodule : sho_core

// ==== core/sho_pkg.sv ====
// Shared constants and carrier types for the subtract and halt execution block
package sho_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] OFF_INSTR  = 12'h000;
  localparam logic [11:0] OFF_ACC    = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_WDT    = 12'h00c;
  localparam logic [11:0] OFF_WAKE   = 12'h010;
  localparam logic [11:0] OFF_FILE   = 12'h200;
  localparam logic [11:0] FILE_MASK  = 12'he00;

  // Operation codes in the instruction word
  localparam logic [1:0] OP_LIT    = 2'h0;
  localparam logic [1:0] OP_REG    = 2'h1;
  localparam logic [1:0] OP_BORROW = 2'h2;
  localparam logic [1:0] OP_HALT   = 2'h3;

  // Instruction cycle timing: four oscillator periods per cycle
  localparam int unsigned OSC_PER_INSTR = 4;
  localparam logic [1:0]  Q_LAST        = 2'(OSC_PER_INSTR - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic       CARRY_NONE  = 1'h1;
  localparam logic [7:0] WDT_CLEAR   = 8'h00;
  localparam logic [7:0] BYTE_ONE    = 8'h01;

  // Instruction word: lit [7:0], file address [14:8], dest [15], op [17:16]
  typedef struct packed {
    logic [1:0] op;
    logic       dest;
    logic [6:0] faddr;
    logic [7:0] lit;
  } sho_instr_t;

  // Status word, bit 6 downward
  typedef struct packed {
    logic busy;
    logic halted;
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic result_null_flag;
    logic half_borrow_flag;
    logic borrow_inv_flag;
  } sho_status_t;

  localparam sho_status_t STATUS_RST = 7'h18;

  typedef enum logic [5:0] {
    SEL_INSTR  = 6'h01,
    SEL_ACC    = 6'h02,
    SEL_STATUS = 6'h04,
    SEL_WDT    = 6'h08,
    SEL_WAKE   = 6'h10,
    SEL_FILE   = 6'h20,
    SEL_NONE   = 6'h00
  } sho_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_EXEC = 3'h4
  } sho_exec_t;

  typedef struct packed {
    sho_exec_t        st;
    logic [1:0]       q;
    sho_instr_t       instr;
    logic [7:0]       acc;
    sho_status_t      status;
    logic [7:0]       watchdog_counter;
    logic [7:0]       prescaler;
    logic [127:0][7:0] file;
    logic             aw_held;
    logic             w_held;
    logic [11:0]      awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sho_state_t;

endpackage : sho_pkg

// ==== core/sho_sub.sv ====
// Eight-bit subtractor with borrow-inverse and half-borrow outputs
`timescale 1ns/100ps
module sho_sub
  import sho_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            borrow_inv,
  output logic            half_borrow,
  output logic            result_null
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Two's complement: a + ~b + carry; carry out of 1 means no borrow
  always_comb
  begin
    full_sum    = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low_sum     = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    result      = full_sum[7:0];
    borrow_inv  = full_sum[8];
    half_borrow = low_sum[4];
    result_null = (full_sum[7:0] == 8'h00);
  end

endmodule : sho_sub

// ==== test/sho_core_test.sv ====
// Directed register-level bench for the subtract and halt core
`timescale 1ns/100ps
module sho_core_test;
  import sho_pkg::*;
  logic        core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, halted;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          num_errors, n_compared, cycles;

  sho_core i_sho_core (.core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .halted(halted));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // A hung handshake would otherwise stall the run forever
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // Handshakes are judged at the falling edge, where outputs have settled
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_take;
    logic w_take;
    logic b_seen;
    logic b_take;
    b_take = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wvalid  <= 1'b1;
    // Response ready comes late so the held response is exercised
    while (!b_take)
    begin
      @(negedge core_clk);
      aw_take = awvalid && awready;
      w_take  = wvalid && wready;
      b_seen  = bvalid;
      b_take  = bvalid && bready;
      resp    = bresp;
      @(posedge core_clk);
      if (aw_take)
        awvalid <= 1'b0;
      if (w_take)
        wvalid <= 1'b0;
      if (b_seen && !b_take)
        bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_take;
    logic r_seen;
    logic r_take;
    r_take = 1'b0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    while (!r_take)
    begin
      @(negedge core_clk);
      ar_take = arvalid && arready;
      r_seen  = rvalid;
      r_take  = rvalid && rready;
      v       = rdata;
      resp    = rresp;
      @(posedge core_clk);
      if (ar_take)
        arvalid <= 1'b0;
      if (r_seen && !r_take)
        rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask : rd

  // Returns {null, half_borrow, borrow_inv, result}, status bit order
  function automatic logic [10:0] ref_sub(input logic [7:0] m, input logic [7:0] w,
                                          input logic bi);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} - {1'b0, w} - {8'h0, !bi};
    low  = {1'b0, m[3:0]} - {1'b0, w[3:0]} - {4'h0, !bi};
    return {full[7:0] == 8'h00, !low[4], !full[8], full[7:0]};
  endfunction : ref_sub

  task automatic run(input logic [1:0] op, input logic dest, input logic [6:0] f,
                     input logic [7:0] k, input logic [1:0] exp_resp);
    sho_instr_t ins;
    ins = '{op: op, dest: dest, faddr: f, lit: k};
    wr(OFF_INSTR, 32'(ins), r);
    check(32'(r), 32'(exp_resp), "instruction response");
    // Issue to commit is at most eight clocks
    repeat (8) @(posedge core_clk);
    rd(OFF_STATUS, d, r);
    check(32'(d[6]), 32'h0, "busy after cycle");
  endtask : run

  task automatic sub_case(input logic [1:0] op, input logic dest, input logic [6:0] f,
                          input logic [7:0] fv, input logic [7:0] w, input logic [7:0] k,
                          input logic bi);
    logic [10:0] e;
    logic        to_file;
    e = ref_sub(op == OP_LIT ? k : fv, w, op == OP_BORROW ? bi : CARRY_NONE);
    to_file = dest && op != OP_LIT;
    wr(OFF_ACC, 32'(w), r);
    wr(OFF_FILE + {3'h0, f, 2'h0}, 32'(fv), r);
    wr(OFF_STATUS, 32'(bi), r);
    run(op, dest, f, k, RESP_OKAY);
    rd(OFF_ACC, d, r);
    check(d, 32'(to_file ? w : e[7:0]), "accumulator");
    rd(OFF_FILE + {3'h0, f, 2'h0}, d, r);
    check(d, 32'(to_file ? e[7:0] : fv), "file register");
    rd(OFF_STATUS, d, r);
    check(d, {25'h0, 4'h3, e[10:8]}, "arithmetic flags");
    $display("subtract case op %0d dest %0d done", op, dest);
  endtask : sub_case

  initial
  begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFF_STATUS, d, r);
    check(d, 32'h18, "status after reset");
    rd(OFF_ACC, d, r);
    check(d, 32'h0, "accumulator after reset");
    $display("reset test done");
    sub_case(OP_LIT, 1'b0, 7'h00, 8'h00, 8'h30, 8'h20, 1'b1);
    sub_case(OP_LIT, 1'b1, 7'h00, 8'h00, 8'hff, 8'hff, 1'b0);
    sub_case(OP_REG, 1'b0, 7'h7f, 8'h05, 8'h06, 8'h00, 1'b1);
    sub_case(OP_REG, 1'b1, 7'h00, 8'h45, 8'h45, 8'h00, 1'b0);
    sub_case(OP_BORROW, 1'b0, 7'h03, 8'h10, 8'hf0, 8'h00, 1'b0);
    sub_case(OP_BORROW, 1'b1, 7'h09, 8'h80, 8'h01, 8'h00, 1'b1);
    rd(12'h020, d, r);
    check({d[29:0], r}, 32'(RESP_SLVERR), "unmapped read");
    wr(12'h014, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped write");
    $display("unmapped test done");
    run(OP_HALT, 1'b0, 7'h00, 8'h00, RESP_OKAY);
    check(32'(halted), 32'h1, "halted");
    rd(OFF_STATUS, d, r);
    check(32'(d[5:3]), 32'h6, "halt status bits");
    // Watchdog must stay cleared because the oscillator is stopped
    repeat (40) @(posedge core_clk);
    wr(OFF_WDT, 32'hffff, r);
    check(32'(r), 32'(RESP_OKAY), "watchdog write ignored");
    rd(OFF_WDT, d, r);
    check(d, 32'h0, "watchdog and prescaler");
    rd(OFF_ACC, d, r);
    check(d, 32'h01, "accumulator before refusal");
    run(OP_LIT, 1'b0, 7'h00, 8'h77, RESP_SLVERR);
    rd(OFF_ACC, d, r);
    check(d, 32'h01, "accumulator while halted");
    wr(OFF_WAKE, 32'h1, r);
    check(32'(halted), 32'h0, "halted after wake");
    $display("halt test done");
    complete_run();
  end
endmodule : sho_core_test

bind sho_core sho_monitor i_sho_monitor (.core_clk(core_clk), .sys_rst(sys_rst),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .halted(halted));

// ==== test/sho_monitor.sv ====
// Port-level assertions for the subtract and halt core
`timescale 1ns/100ps
module sho_monitor
  import sho_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [11:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        halted
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic mapped;
  // File window decodes by mask, the rest are single words
  assign mapped = ((araddr & FILE_MASK) == OFF_FILE) ||
                  (araddr inside {OFF_INSTR, OFF_ACC, OFF_STATUS, OFF_WDT, OFF_WAKE});
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  wr_latency_a: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response not on time");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  rd_latency_a: assert property (rd_taken |=> rvalid)
    else $error("read data not on time");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  rd_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  unmapped_rd_a: assert property (rd_taken ##0 !mapped |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read accepted");
  halt_refuse_a: assert property (
    wr_taken ##0 (halted && awaddr == OFF_INSTR) |-> ##2 bresp == RESP_SLVERR)
    else $error("instruction accepted while halted");
  halt_wdt_a: assert property (
    rd_taken ##0 (halted && araddr == OFF_WDT) |=> rdata[15:0] == 16'h0)
    else $error("watchdog not clear while halted");
  halt_flags_a: assert property (
    rd_taken ##0 (halted && araddr == OFF_STATUS) |=> rdata[5:3] == 3'h6)
    else $error("halt status bits wrong");
endmodule : sho_monitor
